// >>> pkg/epfd_pkg.sv
// Package of constants and types for the parallel port FIFO/DMA block
package epfd_pkg;
	// APB register byte addresses
	localparam logic [11:0] ADDR_CMD_QUEUE   = 12'h000; // Address/command queue
	localparam logic [11:0] ADDR_DATA_QUEUE  = 12'h400; // Data and test queue
	localparam logic [11:0] ADDR_CTRL        = 12'h404; // Control register
	localparam logic [11:0] ADDR_STATUS      = 12'h408; // Status register
	// Control register fields
	localparam int CTRL_MODE_LSB  = 0;  // Mode, 3 bits
	localparam int CTRL_DIR_BIT   = 3;  // Direction, 1 = reverse
	localparam int CTRL_INH_BIT   = 4;  // Service irq inhibit
	localparam int CTRL_DMA_BIT   = 5;  // DMA gate
	localparam int CTRL_FLT_BIT   = 6;  // Fault irq enable, active low
	localparam int CTRL_ACK_BIT   = 7;  // Ack irq enable
	localparam int CTRL_THR_LSB   = 8;  // Threshold field, 4 bits
	localparam logic [11:0] CTRL_RESET = 12'h050; // Inhibit=1, fault en_n=1
	// Status register fields
	localparam int STAT_EMPTY_BIT = 0;
	localparam int STAT_FULL_BIT  = 1;
	localparam int STAT_CNT_LSB   = 2;  // Fill level, 5 bits
	// Modes
	localparam logic [2:0] MODE_STD    = 3'h0;
	localparam logic [2:0] MODE_FIFO   = 3'h2;
	localparam logic [2:0] MODE_ECP    = 3'h3;
	localparam logic [2:0] MODE_TEST   = 3'h6;
	// Queue geometry
	localparam int          QUEUE_DEPTH = 16;
	localparam logic [4:0]  QUEUE_FULL  = 5'h10;
	localparam logic [4:0]  THR_MAX     = 5'h0F; // Threshold 16 acts as 15
	localparam logic        CMD_RLE     = 1'b0;  // Command D7 value for count
	// Timing
	localparam int CLK_HZ          = 40_000_000;
	localparam int DACK_GAP_NS     = 350;
	localparam int DACK_GAP_CYC    =
		(DACK_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // Rounded up
	localparam logic [5:0] DMA_BURST_MAX = 6'h20; // 32 cycles in a row
	localparam logic [1:0] IRQ_PULSE_CYC = 2'h3;  // Low pulse length
	// Queue entry: byte plus command flag
	typedef struct packed {
		logic       is_cmd; // 1 = command byte
		logic [7:0] data;
	} epfd_entry_s;
	// Forward link byte toward the peripheral
	typedef struct packed {
		logic       host_ack; // 1 = data, 0 = command
		logic [7:0] data;
	} epfd_fwd_s;
	typedef enum logic [1:0] {
		FWD_IDLE,
		FWD_SEND,
		FWD_WAIT
	} epfd_fwd_e;
endpackage

// >>> hw/epfd_core.sv
// Parallel port FIFO, RLE expansion, service interrupts and DMA pacing
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module epfd_core (
	input  wire logic        CLK_SYS_IN,        // System clock 40 MHz
	input  wire logic        RST_N_IN,          // Async reset, active low
	input  wire logic        PSEL_IN,           // APB select
	input  wire logic        PENABLE_IN,        // APB enable
	input  wire logic        PWRITE_IN,         // APB direction
	input  wire logic [11:0] PADDR_IN,          // APB byte address
	input  wire logic [31:0] PWDATA_IN,         // APB write data
	output logic      [31:0] PRDATA_OUT,        // APB read data
	output logic             PREADY_OUT,        // APB ready
	output logic             PSLVERR_OUT,       // APB error
	input  wire logic        PORT_DMA_ACK_N_IN, // DMA acknowledge
	input  wire logic        DMA_TC_IN,         // DMA terminal count
	input  wire logic [7:0]  DMA_WDATA_IN,      // DMA byte to queue
	output logic      [7:0]  DMA_RDATA_OUT,     // DMA byte from queue
	output logic             PORT_DMA_REQUEST_OUT, // DMA request
	output logic             PORT_IRQ_OUT,      // Irq line level (low)
	output logic             PORT_IRQ_OE_OUT,   // Irq line drive enable
	input  wire logic        FAULT_N_IN,        // Peripheral nFault pin
	input  wire logic        ACK_N_IN,          // Peripheral nAck pin
	input  wire logic        PERIPH_ACK_IN,     // Reverse data/cmd mark
	input  wire logic        REV_VALID_IN,      // Reverse byte strobe
	input  wire logic [7:0]  REV_DATA_IN,       // Reverse byte
	output logic             REV_READY_OUT,     // Room for reverse byte
	output logic      [7:0]  FWD_DATA_OUT,      // Forward byte
	output logic             FWD_HOST_ACK_OUT,  // Forward data/cmd mark
	output logic             FWD_VALID_OUT,     // Forward byte valid
	input  wire logic        FWD_TAKEN_IN,      // Peripheral took byte
	output logic             CTRL_PUSH_PULL_OUT // Control drivers push-pull
);
	localparam int CW = $clog2(epfd_pkg::DACK_GAP_CYC + 1);

	// Register state
	logic [11:0] ctrl_reg;                    // Control register
	logic [2:0]  mode;                        // Current mode
	logic        dir_rev;                     // Reverse direction
	logic        inhibit;                     // Service irq inhibit view
	logic        dma_gate;                    // DMA gate view
	logic [3:0]  thr_field;                   // Programmed threshold
	epfd_pkg::epfd_entry_s mem [epfd_pkg::QUEUE_DEPTH]; // Queue storage
	logic [3:0]  wr_ptr_reg;                  // Write pointer
	logic [3:0]  rd_ptr_reg;                  // Read pointer
	logic [4:0]  count_reg;                   // Fill level
	logic        q_empty;                     // Queue empty
	logic        q_full;                      // Queue full
	logic        q_enabled;                   // Queue in use
	logic        push;                        // Write one entry
	logic        pop;                         // Read one entry
	logic        fwd_pop;                     // Forward engine takes head
	epfd_pkg::epfd_entry_s push_entry;        // Entry to write
	epfd_pkg::epfd_entry_s head;              // Oldest entry
	// Pin synchronisers
	logic [1:0]  fault_sync_reg;              // nFault synchroniser
	logic [1:0]  ack_sync_reg;                // nAck synchroniser
	logic [1:0]  dack_sync_reg;               // DMA ack synchroniser
	logic [1:0]  tc_sync_reg;                 // Terminal count sync
	logic        fault_prev_reg;              // Last synced nFault
	logic        ack_prev_reg;                // Last synced nAck
	logic        dack_prev_reg;               // Last synced ack
	logic        flt_en_prev_reg;             // Last fault enable_n
	logic        inh_prev_reg;                // Last inhibit value
	// Bus decode
	logic        apb_access;                  // Access phase
	logic        apb_wr;                      // Write completes
	logic        apb_rd;                      // Read completes
	logic        dma_cycle;                   // DACK active edge
	// Forward engine
	epfd_pkg::epfd_fwd_e fwd_state_reg;       // Forward state
	logic [7:0]  rle_left_reg;                // Copies still to send
	logic        rle_pend_reg;                // Count waiting for byte
	// Interrupt and DMA
	logic [4:0]  thr_eff;                     // Clamped threshold
	logic [4:0]  free_cnt;                    // Free positions
	logic        svc_cond;                    // Service condition holds
	logic        svc_fire;                    // Service event
	logic        err_fire;                    // Fault/ack event
	logic        tc_hit;                      // Qualified terminal count
	logic [1:0]  pulse_reg;                   // Irq pulse timer
	logic [5:0]  burst_reg;                   // DMA cycles in a row
	logic        burst_hold_reg;              // Waiting for DACK gap
	logic [CW-1:0] gap_reg;                   // DACK high time

	assign mode      = ctrl_reg[epfd_pkg::CTRL_MODE_LSB +: 3];
	assign dir_rev   = ctrl_reg[epfd_pkg::CTRL_DIR_BIT];
	assign inhibit   = ctrl_reg[epfd_pkg::CTRL_INH_BIT];
	assign dma_gate  = ctrl_reg[epfd_pkg::CTRL_DMA_BIT];
	assign thr_field = ctrl_reg[epfd_pkg::CTRL_THR_LSB +: 4];

	// Queue only works in FIFO, ECP and test modes
	assign q_enabled = (mode == epfd_pkg::MODE_FIFO) ||
		(mode == epfd_pkg::MODE_ECP) || (mode == epfd_pkg::MODE_TEST);
	assign q_empty = (count_reg == 5'h00);
	assign q_full  = (count_reg == epfd_pkg::QUEUE_FULL);
	assign head    = mem[rd_ptr_reg];

	// APB decode, zero wait states
	assign apb_access = PSEL_IN && PENABLE_IN;
	assign apb_wr     = apb_access && PWRITE_IN;
	assign apb_rd     = apb_access && !PWRITE_IN;
	// Acknowledge alone selects the queue, no address needed
	assign dma_cycle  = dack_prev_reg && !dack_sync_reg[1];

	// Pin synchronisers and edge history
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fault_sync_reg <= 2'h3;
			ack_sync_reg   <= 2'h3;
			dack_sync_reg  <= 2'h3;
			tc_sync_reg    <= 2'h0;
			fault_prev_reg <= 1'b1;
			ack_prev_reg   <= 1'b1;
			dack_prev_reg  <= 1'b1;
		end else begin
			fault_sync_reg <= {fault_sync_reg[0], FAULT_N_IN};
			ack_sync_reg   <= {ack_sync_reg[0], ACK_N_IN};
			dack_sync_reg  <= {dack_sync_reg[0], PORT_DMA_ACK_N_IN};
			tc_sync_reg    <= {tc_sync_reg[0], DMA_TC_IN};
			fault_prev_reg <= fault_sync_reg[1];
			ack_prev_reg   <= ack_sync_reg[1];
			dack_prev_reg  <= dack_sync_reg[1];
		end
	end

	// Push source: PIO write, DMA write, or reverse link byte
	always_comb begin
		push = 1'b0;
		push_entry = '0;
		if (q_enabled && !q_full) begin
			if (apb_wr && PADDR_IN == epfd_pkg::ADDR_DATA_QUEUE) begin
				push = 1'b1;
				push_entry = {1'b0, PWDATA_IN[7:0]};
			end else if (apb_wr &&
				PADDR_IN == epfd_pkg::ADDR_CMD_QUEUE && !dir_rev) begin
				// Count or channel, sent with HostAck low
				push = 1'b1;
				push_entry = {1'b1, PWDATA_IN[7:0]};
			end else if (dma_cycle && !dir_rev) begin
				push = 1'b1;
				push_entry = {1'b0, DMA_WDATA_IN};
			end else if (REV_VALID_IN && dir_rev &&
				mode == epfd_pkg::MODE_ECP) begin
				// PeriphAck low marks a command; D7 is stored as sent
				push = 1'b1;
				push_entry = {!PERIPH_ACK_IN, REV_DATA_IN};
			end
		end
	end

	// Pop source: PIO read in any queue mode, DMA read in reverse, forward engine
	always_comb begin
		pop = 1'b0;
		fwd_pop = 1'b0;
		if (q_enabled && !q_empty) begin
			if (apb_rd && PADDR_IN == epfd_pkg::ADDR_DATA_QUEUE)
				pop = 1'b1;
			else if (dma_cycle && dir_rev)
				pop = 1'b1;
			else if (fwd_state_reg == epfd_pkg::FWD_IDLE && !dir_rev &&
				mode != epfd_pkg::MODE_TEST &&
				(rle_left_reg == 8'h00 || rle_pend_reg)) begin
				// A pending count lets its data byte through
				pop     = 1'b1;
				fwd_pop = 1'b1;
			end
		end
	end

	// Queue storage
	always_ff @(posedge CLK_SYS_IN) begin
		if (push)
			mem[wr_ptr_reg] <= push_entry;
	end

	// Queue pointers and fill level; cleared outside queue modes
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			count_reg  <= 5'h00;
		end else if (!q_enabled) begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			count_reg  <= 5'h00;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 4'h1;
			if (push && !pop)
				count_reg <= count_reg + 5'h01;
			else if (pop && !push)
				count_reg <= count_reg - 5'h01;
		end
	end

	// Forward engine with run-length expansion
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fwd_state_reg    <= epfd_pkg::FWD_IDLE;
			rle_left_reg     <= 8'h00;
			rle_pend_reg     <= 1'b0;
			FWD_DATA_OUT     <= 8'h00;
			FWD_HOST_ACK_OUT <= 1'b1;
			FWD_VALID_OUT    <= 1'b0;
		end else begin
			case (fwd_state_reg)
			epfd_pkg::FWD_IDLE: begin
				if (fwd_pop) begin
					FWD_DATA_OUT     <= head.data;
					FWD_HOST_ACK_OUT <= !head.is_cmd;
					FWD_VALID_OUT    <= 1'b1;
					fwd_state_reg    <= epfd_pkg::FWD_WAIT;
				end else if (rle_left_reg != 8'h00 && !rle_pend_reg) begin
					// Repeat the data byte still on the link
					FWD_VALID_OUT <= 1'b1;
					rle_left_reg  <= rle_left_reg - 8'h01;
					fwd_state_reg <= epfd_pkg::FWD_WAIT;
				end
			end
			epfd_pkg::FWD_WAIT: begin
				if (FWD_TAKEN_IN) begin
					FWD_VALID_OUT <= 1'b0;
					fwd_state_reg <= epfd_pkg::FWD_SEND;
				end
			end
			epfd_pkg::FWD_SEND: begin
				// One idle cycle between bytes
				fwd_state_reg <= epfd_pkg::FWD_IDLE;
			end
			default: fwd_state_reg <= epfd_pkg::FWD_IDLE;
			endcase
			if (!q_enabled || dir_rev) begin
				rle_left_reg <= 8'h00;
				rle_pend_reg <= 1'b0;
			end else if (fwd_pop && head.is_cmd) begin
				// D7 low: count held until its data byte goes out
				rle_pend_reg <= (head.data[7] == epfd_pkg::CMD_RLE);
				rle_left_reg <= (head.data[7] == epfd_pkg::CMD_RLE) ?
					{1'b0, head.data[6:0]} : 8'h00;
			end else if (fwd_pop) begin
				rle_pend_reg <= 1'b0;
			end
		end
	end

	// Thresholds: field plus one, 16 behaves as 15
	assign thr_eff  = (5'(thr_field) + 5'h01 > epfd_pkg::THR_MAX) ?
		epfd_pkg::THR_MAX : 5'(thr_field) + 5'h01;
	assign free_cnt = epfd_pkg::QUEUE_FULL - count_reg;
	always_comb begin
		svc_cond = 1'b0;
		if (q_enabled && !dma_gate) begin
			if (!dir_rev)
				svc_cond = free_cnt >= epfd_pkg::QUEUE_FULL - thr_eff;
			else
				svc_cond = count_reg >= epfd_pkg::QUEUE_FULL - thr_eff;
		end
	end
	assign tc_hit   = tc_sync_reg[1] && !dack_sync_reg[1];
	// Level condition seen while uninhibited also covers the 1-to-0 case
	assign svc_fire = !inhibit && (svc_cond || (dma_gate && tc_hit));
	assign err_fire =
		(!ctrl_reg[epfd_pkg::CTRL_FLT_BIT] && fault_prev_reg &&
		 !fault_sync_reg[1]) ||
		(flt_en_prev_reg && !ctrl_reg[epfd_pkg::CTRL_FLT_BIT] &&
		 !fault_sync_reg[1]) ||
		(ctrl_reg[epfd_pkg::CTRL_ACK_BIT] && !ack_prev_reg &&
		 ack_sync_reg[1]);

	// Control register; hardware set of inhibit wins over a clear
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_reg        <= epfd_pkg::CTRL_RESET;
			flt_en_prev_reg <= 1'b1;
			inh_prev_reg    <= 1'b1;
		end else begin
			flt_en_prev_reg <= ctrl_reg[epfd_pkg::CTRL_FLT_BIT];
			inh_prev_reg    <= inhibit;
			if (apb_wr && PADDR_IN == epfd_pkg::ADDR_CTRL)
				ctrl_reg <= PWDATA_IN[11:0];
			if (svc_fire)
				ctrl_reg[epfd_pkg::CTRL_INH_BIT] <= 1'b1;
		end
	end

	// Interrupt pulse: drive low briefly, then release
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pulse_reg       <= 2'h0;
			PORT_IRQ_OUT    <= 1'b0;
			PORT_IRQ_OE_OUT <= 1'b0;
		end else begin
			PORT_IRQ_OUT <= 1'b0;
			if (svc_fire || err_fire) begin
				pulse_reg       <= epfd_pkg::IRQ_PULSE_CYC;
				PORT_IRQ_OE_OUT <= 1'b1;
			end else if (pulse_reg > 2'h1) begin
				pulse_reg <= pulse_reg - 2'h1;
			end else begin
				pulse_reg       <= 2'h0;
				PORT_IRQ_OE_OUT <= 1'b0;
			end
		end
	end

	// DMA burst limit: 32 cycles, then wait for 350 ns of DACK high
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			burst_reg      <= 6'h00;
			burst_hold_reg <= 1'b0;
			gap_reg        <= '0;
		end else begin
			if (dma_cycle)
				burst_reg <= burst_reg + 6'h01;
			if (dma_cycle && burst_reg + 6'h01 >= epfd_pkg::DMA_BURST_MAX)
				burst_hold_reg <= 1'b1;
			gap_reg <= dack_sync_reg[1] ? ((gap_reg ==
				CW'(epfd_pkg::DACK_GAP_CYC)) ? gap_reg : gap_reg + 1'b1)
				: '0;
			if (burst_hold_reg &&
				gap_reg == CW'(epfd_pkg::DACK_GAP_CYC)) begin
				burst_hold_reg <= 1'b0;
				burst_reg      <= 6'h00;
			end
			if (!PORT_DMA_REQUEST_OUT && !burst_hold_reg && !dma_cycle)
				burst_reg <= 6'h00;
		end
	end

	// DMA request: gated, drops on empty/full or TC, uninhibit needed
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			PORT_DMA_REQUEST_OUT <= 1'b0;
		else
			PORT_DMA_REQUEST_OUT <= q_enabled && dma_gate && !inhibit &&
				!tc_hit && !burst_hold_reg &&
				(dir_rev ? (count_reg > 5'h01 ||
				 (count_reg == 5'h01 && !pop)) :
				 (count_reg < epfd_pkg::QUEUE_FULL - 5'h01));
	end

	// Driver type, DMA read data and reverse room
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CTRL_PUSH_PULL_OUT <= 1'b0;
			DMA_RDATA_OUT      <= 8'h00;
			REV_READY_OUT      <= 1'b0;
		end else begin
			CTRL_PUSH_PULL_OUT <= (mode != epfd_pkg::MODE_STD);
			if (dir_rev)
				DMA_RDATA_OUT <= head.data;
			REV_READY_OUT <= q_enabled && dir_rev &&
				count_reg < epfd_pkg::QUEUE_FULL - 5'h01;
		end
	end

	// APB slave: registered read data, zero waits, error on unmapped
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PRDATA_OUT  <= 32'h0000_0000;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h0000_0000;
			if (PSEL_IN && !PENABLE_IN) begin
				case (PADDR_IN)
				epfd_pkg::ADDR_DATA_QUEUE:
					PRDATA_OUT <= {24'h000000, head.data};
				epfd_pkg::ADDR_CMD_QUEUE: ;
				epfd_pkg::ADDR_CTRL:
					PRDATA_OUT <= {20'h00000, ctrl_reg};
				epfd_pkg::ADDR_STATUS:
					PRDATA_OUT <= {25'h0000000, count_reg,
						q_full, q_empty};
				default: PSLVERR_OUT <= 1'b1;
				endcase
			end
		end
	end
endmodule

// >>> testbench/epfd_monitor.sv
// Checker for the parallel port FIFO/DMA core ports
`timescale 1ns/1ps
module epfd_monitor (
	input wire logic        CLK_SYS_IN,
	input wire logic        RST_N_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        PORT_DMA_ACK_N_IN,
	input wire logic        DMA_TC_IN,
	input wire logic        PORT_DMA_REQUEST_OUT,
	input wire logic        PORT_IRQ_OUT,
	input wire logic        PORT_IRQ_OE_OUT,
	input wire logic        FWD_VALID_OUT,
	input wire logic        FWD_TAKEN_IN,
	input wire logic [7:0]  FWD_DATA_OUT,
	input wire logic        FWD_HOST_ACK_OUT,
	input wire logic        CTRL_PUSH_PULL_OUT
);
	logic [5:0] burst_reg; // Raw ack cycles while request held
	logic       done_reg;  // A full burst of 32 was seen
	logic [4:0] hi_reg;    // Ack high run, saturating
	logic       ack_reg;   // Ack one cycle ago
	logic [2:0] mode_reg;  // Last mode written
	logic [1:0] age_reg;   // Cycles since that write
	logic       acc;       // Completed APB access
	assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	// Burst and gap bookkeeping; raw ack leads the core's synced copy
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			burst_reg <= 6'h00;
			done_reg <= 1'b0;
			hi_reg <= 5'h00;
			ack_reg <= 1'b1;
		end else begin
			ack_reg <= PORT_DMA_ACK_N_IN;
			if (!PORT_DMA_REQUEST_OUT)
				burst_reg <= 6'h00;
			else if (ack_reg && !PORT_DMA_ACK_N_IN)
				burst_reg <= burst_reg + 6'h01;
			if (burst_reg == 6'h20)
				done_reg <= 1'b1;
			else if (PORT_DMA_REQUEST_OUT)
				done_reg <= 1'b0;
			if (!PORT_DMA_ACK_N_IN)
				hi_reg <= 5'h00;
			else if (hi_reg != 5'h1F)
				hi_reg <= hi_reg + 5'h01;
		end
	end
	// Mode tracking, so the driver type is judged once settled
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			mode_reg <= 3'h0;
			age_reg <= 2'h3;
		end else if (acc && PWRITE_IN && PADDR_IN == epfd_pkg::ADDR_CTRL) begin
			mode_reg <= PWDATA_IN[2:0];
			age_reg <= 2'h0;
		end else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	a_irq_low_only: assert property (
		PORT_IRQ_OE_OUT |-> !PORT_IRQ_OUT) else $error("irq driven high");
	a_irq_pulse_len: assert property (
		$rose(PORT_IRQ_OE_OUT) |-> PORT_IRQ_OE_OUT[*3] ##1 !PORT_IRQ_OE_OUT)
		else $error("irq pulse length wrong");
	a_fwd_byte_hold: assert property (
		FWD_VALID_OUT && !FWD_TAKEN_IN |=> FWD_VALID_OUT
		&& $stable(FWD_DATA_OUT) && $stable(FWD_HOST_ACK_OUT))
		else $error("forward byte not held");
	a_slverr_map: assert property (
		acc |-> PSLVERR_OUT == !(PADDR_IN inside {12'h000, 12'h400,
		12'h404, 12'h408})) else $error("error response wrong");
	a_drive_type: assert property (
		age_reg == 2'h3 |-> CTRL_PUSH_PULL_OUT == (mode_reg != 3'h0))
		else $error("driver type wrong");
	a_burst_limit: assert property (
		burst_reg <= 6'h20) else $error("dma burst too long");
	a_dack_gap: assert property (
		$rose(PORT_DMA_REQUEST_OUT) && done_reg |-> hi_reg >= 5'd14)
		else $error("dma gap too short");
	a_tc_drop: assert property (
		!PORT_DMA_ACK_N_IN && DMA_TC_IN |-> ##[1:4] !PORT_DMA_REQUEST_OUT)
		else $error("request kept after tc");
endmodule
bind epfd_core epfd_monitor u_mon (.*);

// >>> testbench/epfd_periph.sv
// ECP peripheral model: forward byte sink, reverse byte source
`timescale 1ns/1ps
module epfd_periph (
	input  wire logic       clk_in,            // System clock
	input  wire logic       rst_n_in,          // Reset, active low
	input  wire logic       slow_in,           // Answer late when high
	input  wire logic       valid_in,          // Forward byte offered
	input  wire logic [8:0] fwd_in,            // Forward mark and byte
	input  wire logic       ready_in,          // Core has room
	output logic            taken_out = 1'b0,  // Forward byte taken
	output logic            rvalid_out = 1'b0, // Reverse byte strobe
	output logic      [7:0] rdata_out = 8'h00  // Reverse byte
);
	logic [8:0] log_q[$]; // Forward bytes in arrival order
	logic [7:0] tx_q[$];  // Reverse bytes still to send
	int         dly = 0;  // Slow answer counter
	// Forward sink; a slow peer stalls three cycles per byte
	always @(posedge clk_in) begin
		taken_out <= 1'b0;
		if (rst_n_in && valid_in && !taken_out) begin
			if (slow_in && dly < 3)
				dly <= dly + 1;
			else begin
				dly <= 0;
				taken_out <= 1'b1;
				log_q.push_back(fwd_in);
			end
		end
	end
	// Reverse source; bus shows junk outside a strobe
	always @(posedge clk_in) begin
		rvalid_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (rst_n_in && ready_in && !rvalid_out && tx_q.size() > 0) begin
			rvalid_out <= 1'b1;
			rdata_out <= tx_q.pop_front();
		end
	end
endmodule

// >>> testbench/epfd_core_bench.sv
// Self-checking bench for the parallel port FIFO/DMA core
`timescale 1ns/1ps
module epfd_core_bench;
	localparam logic [11:0] ctl_a = epfd_pkg::ADDR_CTRL;
	localparam logic [11:0] dat_a = epfd_pkg::ADDR_DATA_QUEUE;
	localparam logic [11:0] sta_a = epfd_pkg::ADDR_STATUS;
	logic CLK_SYS_IN = 1'b0, RST_N_IN = 1'b0, PSEL_IN = 1'b0, err, fire;
	logic PENABLE_IN = 1'b0, PWRITE_IN = 1'b0, PORT_DMA_ACK_N_IN = 1'b1;
	logic DMA_TC_IN = 1'b0, FAULT_N_IN = 1'b1, ACK_N_IN = 1'b1, slow = 1'b0;
	logic PERIPH_ACK_IN = 1'b1;
	logic REV_VALID_IN, FWD_TAKEN_IN, PREADY_OUT, PSLVERR_OUT, FWD_VALID_OUT;
	logic PORT_DMA_REQUEST_OUT, PORT_IRQ_OUT, PORT_IRQ_OE_OUT, REV_READY_OUT;
	logic FWD_HOST_ACK_OUT, CTRL_PUSH_PULL_OUT;
	logic [11:0] PADDR_IN = 12'h000;
	logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd;
	logic [7:0] DMA_WDATA_IN = 8'h00, DMA_RDATA_OUT, REV_DATA_IN, FWD_DATA_OUT;
	logic [8:0] exp_q[$]; // Expected forward bytes
	logic [7:0] q[$];     // Expected queue contents
	int bad_count = 0, cmp_count = 0, t, k, n, i, j;
	int ct[3] = '{15, 15, 14}, ck[3] = '{15, 16, 16}; // Threshold corners
	always #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
	epfd_core u_dut (.*);
	epfd_periph u_per (.clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
		.slow_in(slow), .valid_in(FWD_VALID_OUT),
		.fwd_in({FWD_HOST_ACK_OUT, FWD_DATA_OUT}), .ready_in(REV_READY_OUT),
		.taken_out(FWD_TAKEN_IN), .rvalid_out(REV_VALID_IN),
		.rdata_out(REV_DATA_IN));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge CLK_SYS_IN);
		PSEL_IN <= 1'b1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		@(posedge CLK_SYS_IN);
		PENABLE_IN <= 1'b1;
		do @(posedge CLK_SYS_IN); while (!PREADY_OUT);
		rd = PRDATA_OUT;
		err = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Control word from its fields
	function automatic logic [31:0] cw(input logic [2:0] m, input logic dr,
		ih, dm, fn, ak, input logic [3:0] th);
		return {20'h0, th, ak, fn, dm, ih, dr, m};
	endfunction
	// Mode change always passes through mode 001
	task automatic set_mode(input logic [2:0] m, input logic dr,
		input logic [3:0] th);
		wr(ctl_a, cw(3'h1, dr, 1'b1, 1'b0, 1'b1, 1'b0, th));
		wr(ctl_a, cw(m, dr, 1'b1, 1'b0, 1'b1, 1'b0, th));
	endtask
	// Watch the irq drive for ten cycles
	task automatic irq_chk(input logic e);
		logic s;
		s = 1'b0;
		repeat (10) begin
			@(negedge CLK_SYS_IN);
			s = s | PORT_IRQ_OE_OUT;
		end
		chk(s, e);
		@(posedge CLK_SYS_IN);
	endtask
	// Effective threshold, 16 clamps to 15
	function automatic int thr(input int f);
		return f + 1 > 15 ? 15 : f + 1;
	endfunction
	task automatic rle(input logic [7:0] c, input logic [7:0] b);
		wr(epfd_pkg::ADDR_CMD_QUEUE, {24'h0, c});
		wr(dat_a, {24'h0, b});
		exp_q.push_back({1'b0, c});
		repeat (c + 1) exp_q.push_back({1'b1, b});
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(25 * 60000);
		bad_count++;
		end_sim();
	end
	initial begin
		n = $urandom(78796);
		repeat (16) @(posedge CLK_SYS_IN);
		RST_N_IN <= 1'b1;
		apb(1'b0, ctl_a, 0); chk(rd, 32'h050);
		apb(1'b0, sta_a, 0); chk(rd, 32'h1);
		apb(1'b0, 12'h010, 0); chk(err, 1'b1);
		for (k = 0; k < 8; k++) begin
			set_mode(k[2:0], 1'b0, 4'h0);
			repeat (4) @(posedge CLK_SYS_IN);
			chk(CTRL_PUSH_PULL_OUT, k != 0);
		end
		// Free space threshold in test mode, overflow refused
		for (n = 0; n < 8; n++) begin
			t = n < 3 ? ct[n] : $urandom % 16;
			k = n < 3 ? ck[n] : $urandom % 17;
			set_mode(epfd_pkg::MODE_TEST, 1'b0, t[3:0]);
			for (i = 0; i < k + (k == 16); i++) begin
				j = $urandom % 256;
				wr(dat_a, j);
				if (i < 16) q.push_back(j[7:0]);
			end
			apb(1'b0, sta_a, 0);
			chk(rd, (k << 2) | ((k == 16) << 1) | (k == 0));
			fire = k <= thr(t);
			wr(ctl_a, cw(epfd_pkg::MODE_TEST, 0, 0, 0, 1, 0, t[3:0]));
			irq_chk(fire);
			apb(1'b0, ctl_a, 0); chk(rd[4], fire);
			wr(ctl_a, cw(epfd_pkg::MODE_TEST, 0, 1, 0, 1, 0, t[3:0]));
			while (q.size() > 0) begin
				apb(1'b0, dat_a, 0); chk(rd[7:0], q.pop_front());
			end
		end
		// Fill level threshold, reverse bytes from the peer
		for (n = 0; n < 4; n++) begin
			t = $urandom % 16;
			k = $urandom % 15;
			set_mode(epfd_pkg::MODE_ECP, 1'b1, t[3:0]);
			for (i = 0; i < k; i++) begin
				j = $urandom % 256;
				q.push_back(j[7:0]);
				u_per.tx_q.push_back(j[7:0]);
			end
			rd = 32'h0;
			for (i = 0; i < 60 && rd[6:2] != k; i++) apb(1'b0, sta_a, 0);
			chk(rd[6:2], k);
			wr(ctl_a, cw(epfd_pkg::MODE_ECP, 1, 0, 0, 1, 0, t[3:0]));
			irq_chk(k >= 16 - thr(t));
			wr(ctl_a, cw(epfd_pkg::MODE_ECP, 1, 1, 0, 1, 0, t[3:0]));
			while (q.size() > 0) begin
				apb(1'b0, dat_a, 0); chk(rd[7:0], q.pop_front());
			end
		end
		// Forward run-length expansion and commands
		set_mode(epfd_pkg::MODE_ECP, 1'b0, 4'h0);
		slow <= 1'b1;
		rle(8'h00, $urandom);
		rle(8'h7F, $urandom);
		slow <= 1'b0;
		rle(1 + $urandom % 9, $urandom);
		j = 8'h80 | $urandom % 128;
		wr(epfd_pkg::ADDR_CMD_QUEUE, j);
		exp_q.push_back({1'b0, j[7:0]});
		j = $urandom % 256;
		wr(dat_a, j);
		exp_q.push_back({1'b1, j[7:0]});
		for (i = 0; i < 3000 && u_per.log_q.size() < exp_q.size(); i++)
			@(posedge CLK_SYS_IN);
		chk(u_per.log_q.size(), exp_q.size());
		foreach (exp_q[i]) chk(u_per.log_q[i], exp_q[i]);
		// Reverse DMA: bursts of 32, terminal count, restart
		set_mode(epfd_pkg::MODE_ECP, 1'b1, 4'h0);
		for (i = 0; i < 41; i++) begin
			j = $urandom % 256;
			q.push_back(j[7:0]);
			u_per.tx_q.push_back(j[7:0]);
		end
		wr(ctl_a, cw(epfd_pkg::MODE_ECP, 1, 0, 1, 1, 0, 4'h0));
		for (i = 0; i < 40; i++) begin
			for (j = 0; j < 300 && !PORT_DMA_REQUEST_OUT; j++)
				@(negedge CLK_SYS_IN);
			chk(DMA_RDATA_OUT, q.pop_front());
			@(posedge CLK_SYS_IN);
			PORT_DMA_ACK_N_IN <= 1'b0;
			DMA_TC_IN <= i == 39;
			DMA_WDATA_IN <= $urandom;
			repeat (3) @(posedge CLK_SYS_IN);
			PORT_DMA_ACK_N_IN <= 1'b1;
			DMA_TC_IN <= 1'b0;
			repeat (3) @(posedge CLK_SYS_IN);
		end
		apb(1'b0, ctl_a, 0); chk(rd[4], 1'b1);
		repeat (20) @(posedge CLK_SYS_IN);
		chk(PORT_DMA_REQUEST_OUT, 1'b0);
		wr(ctl_a, cw(epfd_pkg::MODE_ECP, 1, 0, 1, 1, 0, 4'h0));
		for (j = 0; j < 20 && !PORT_DMA_REQUEST_OUT; j++)
			@(negedge CLK_SYS_IN);
		chk(PORT_DMA_REQUEST_OUT, 1'b1);
		// Acknowledge and fault interrupts
		set_mode(3'h0, 1'b0, 4'h0);
		wr(ctl_a, cw(3'h0, 0, 1, 0, 1, 1, 4'h0));
		ACK_N_IN <= 1'b0;
		irq_chk(1'b0);
		ACK_N_IN <= 1'b1;
		irq_chk(1'b1);
		wr(ctl_a, cw(3'h0, 0, 1, 0, 0, 0, 4'h0));
		FAULT_N_IN <= 1'b0;
		irq_chk(1'b1);
		wr(ctl_a, cw(3'h0, 0, 1, 0, 1, 0, 4'h0));
		irq_chk(1'b0);
		wr(ctl_a, cw(3'h0, 0, 1, 0, 0, 0, 4'h0));
		irq_chk(1'b1);
		end_sim();
	end
endmodule
